// ---- logic/cpd_defines.svh ----
// Offsets, field positions, masks and reset values of the clock and power-down control bank
`ifndef CPD_DEFINES_SVH
`define CPD_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CPD_ADDR_GENERAL 8'h00
`define CPD_ADDR_CLK_MODE 8'h01
`define CPD_ADDR_TX_PLL_PD 8'h02
`define CPD_ADDR_RX_PD_LO 8'h03
`define CPD_ADDR_RX_PD_HI 8'h04
`define CPD_ADDR_RX_BIAS_PD 8'h05

// ------------------------------------------------------------
// Reset value and implemented-bit masks
// ------------------------------------------------------------
`define CPD_REG_RESET 8'h00
`define CPD_GENERAL_MASK 8'hc0
`define CPD_CLK_MODE_MASK 8'he6
`define CPD_TX_PLL_PD_MASK 8'hfe
`define CPD_RX_CH_MASK 8'hc0
`define CPD_RX_BIAS_MASK 8'h80

// ------------------------------------------------------------
// General register
// ------------------------------------------------------------
`define CPD_BIT_SOFT_RESET 5

// ------------------------------------------------------------
// Clock mode register
// ------------------------------------------------------------
`define CPD_CLK_MODE_MSB 7
`define CPD_CLK_MODE_LSB 5
`define CPD_CLK_MODE_STANDARD 3'h0
`define CPD_CLK_MODE_CLONE 3'h7
`define CPD_BIT_AUXB_CLKOUT 2
`define CPD_BIT_AUXC_INVERT 1

// ------------------------------------------------------------
// Transmit and PLL power-down register
// ------------------------------------------------------------
`define CPD_TXPD_MSB 7
`define CPD_TXPD_LSB 5
`define CPD_TXPD_A_ONLY 3'h4
`define CPD_TXPD_B_ONLY 3'h2
`define CPD_TXPD_BOTH 3'h7
`define CPD_BIT_TX_DIGITAL 4
`define CPD_BIT_RX_DIGITAL 3
`define CPD_BIT_PLL_PD 2
`define CPD_BIT_PLL_DISCONNECT 1

// ------------------------------------------------------------
// Receive channel and bias power-down registers
// ------------------------------------------------------------
`define CPD_BIT_RX_ANALOG 7
`define CPD_BIT_RX_DC_BIAS 6
`define CPD_BIT_RX_BIAS_ALL 7

`endif

// ---- logic/cpd_pkg.sv ----
// Types shared by the clock and power-down control bank
`default_nettype none

package cpd_pkg;

   // ------------------------------------------------------------
   // Interface clock controls
   // ------------------------------------------------------------
   typedef struct packed {
      logic cloneTiming;
      logic auxBClockOutEnable;
      logic auxBClockInvert;
      logic auxCClockInvert;
   } cpd_clk_ctrl_type;

   // ------------------------------------------------------------
   // Transmit power controls
   // ------------------------------------------------------------
   typedef struct packed {
      logic channelAOff;
      logic channelBOff;
      logic supportOff;
      logic biasPowered;
      logic digitalClockStop;
   } cpd_tx_power_type;

   // ------------------------------------------------------------
   // Receive power controls
   // ------------------------------------------------------------
   typedef struct packed {
      logic chAAnalogOff;
      logic chADcBiasOff;
      logic chBAnalogOff;
      logic chBDcBiasOff;
      logic biasCircuitsOff;
      logic diffRefBufferOff;
      logic bandgapPowered;
      logic digitalOff;
   } cpd_rx_power_type;

   // ------------------------------------------------------------
   // PLL controls
   // ------------------------------------------------------------
   typedef struct packed {
      logic multiplierOff;
      logic outputDisconnect;
      logic bypassed;
      logic relock;
   } cpd_pll_ctrl_type;

endpackage

`default_nettype wire

// ---- logic/cpd_tx_hold.sv ----
// Transmit sample holder: freezes the transmit word while the digital section is unclocked
`timescale 1ns/1ps
`default_nettype none

module cpd_tx_hold #(
   parameter int WIDTH = 12
) (
   input wire logic clk, // System clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic clkEn, // Freezes all state while low
   input wire logic hold, // Digital section unclocked
   input wire logic [WIDTH-1:0] dataIn, // New transmit word
   output logic [WIDTH-1:0] dataOut // Held transmit word
);

   // Update only while clocked, so the last word stays on the output when stopped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dataOut <= '0;
      end else if (clkEn && !hold) begin
         dataOut <= dataIn;
      end
   end

endmodule

`default_nettype wire

// ---- logic/cpd_top.sv ----
// Clock mode and power-down control bank with its decoded control outputs
`timescale 1ns/1ps
`default_nettype none
`include "cpd_defines.svh"

module cpd_top #(
   parameter int TX_WIDTH = 12
) (
   input wire logic clk, // System clock, 100 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic clkEn, // Freezes all state while low
   input wire logic regWrite, // Register write strobe from serial port
   input wire logic regRead, // Register read strobe from serial port
   input wire logic [7:0] regAddr, // Register offset
   input wire logic [7:0] regWriteData, // Write data
   output logic [7:0] regReadData, // Read data, registered
   input wire logic fullDuplex, // Interface runs full duplex
   input wire logic txPathUsed, // Configuration uses the Tx digital path
   input wire logic rxPathUsed, // Configuration uses the Rx digital path
   input wire logic ifaceClock, // Interface clock level from timing logic
   input wire logic auxPinBIn, // Auxiliary pin B input level
   output logic auxPinBOut, // Auxiliary pin B output level
   output logic auxPinBOe, // Auxiliary pin B output enable
   output logic auxPinBData, // Synchronised pin B input
   output logic auxPinCOut, // Auxiliary pin C clock output
   input wire logic [TX_WIDTH-1:0] txDataA, // Tx channel A word
   input wire logic [TX_WIDTH-1:0] txDataB, // Tx channel B word
   output logic [TX_WIDTH-1:0] txHeldA, // Tx channel A word to converter
   output logic [TX_WIDTH-1:0] txHeldB, // Tx channel B word to converter
   output cpd_pkg::cpd_clk_ctrl_type clkCtrl, // Interface clock controls
   output cpd_pkg::cpd_tx_power_type txPower, // Tx power controls
   output cpd_pkg::cpd_rx_power_type rxPower, // Rx power controls
   output cpd_pkg::cpd_pll_ctrl_type pllCtrl // PLL controls
);

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic [7:0] generalCfg;
   logic [7:0] interfaceClockMode;
   logic [7:0] txAndPllPowerDown;
   logic [7:0] rxChannelPowerDownLo;
   logic [7:0] rxChannelPowerDownHi;
   logic [7:0] rxBiasPowerDown;
   logic softResetHit;
   logic [2:0] txPattern;
   logic [2:0] clockModeField;
   logic pinBSync1;
   logic pinBSync2;
   cpd_pkg::cpd_clk_ctrl_type next_clkCtrl;
   cpd_pkg::cpd_tx_power_type next_txPower;
   cpd_pkg::cpd_rx_power_type next_rxPower;
   cpd_pkg::cpd_pll_ctrl_type next_pllCtrl;

   // Address match used by write decode and the soft reset strobe
   function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] offset);
      hitAddr = (addr == offset);
   endfunction

   // Soft reset is a one-shot: it acts on the write itself and is never stored
   assign softResetHit = regWrite && hitAddr(regAddr, `CPD_ADDR_GENERAL)
                         && regWriteData[`CPD_BIT_SOFT_RESET];

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Unimplemented bits are masked at write, so they always read back as zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         generalCfg <= `CPD_REG_RESET;
         interfaceClockMode <= `CPD_REG_RESET;
         txAndPllPowerDown <= `CPD_REG_RESET;
         rxChannelPowerDownLo <= `CPD_REG_RESET;
         rxChannelPowerDownHi <= `CPD_REG_RESET;
         rxBiasPowerDown <= `CPD_REG_RESET;
      end else if (clkEn) begin
         if (softResetHit) begin
            generalCfg <= `CPD_REG_RESET;
            interfaceClockMode <= `CPD_REG_RESET;
            txAndPllPowerDown <= `CPD_REG_RESET;
            rxChannelPowerDownLo <= `CPD_REG_RESET;
            rxChannelPowerDownHi <= `CPD_REG_RESET;
            rxBiasPowerDown <= `CPD_REG_RESET;
         end else if (regWrite) begin
            if (hitAddr(regAddr, `CPD_ADDR_GENERAL)) begin
               generalCfg <= regWriteData & `CPD_GENERAL_MASK;
            end
            if (hitAddr(regAddr, `CPD_ADDR_CLK_MODE)) begin
               interfaceClockMode <= regWriteData & `CPD_CLK_MODE_MASK;
            end
            if (hitAddr(regAddr, `CPD_ADDR_TX_PLL_PD)) begin
               txAndPllPowerDown <= regWriteData & `CPD_TX_PLL_PD_MASK;
            end
            if (hitAddr(regAddr, `CPD_ADDR_RX_PD_LO)) begin
               rxChannelPowerDownLo <= regWriteData & `CPD_RX_CH_MASK;
            end
            if (hitAddr(regAddr, `CPD_ADDR_RX_PD_HI)) begin
               rxChannelPowerDownHi <= regWriteData & `CPD_RX_CH_MASK;
            end
            if (hitAddr(regAddr, `CPD_ADDR_RX_BIAS_PD)) begin
               rxBiasPowerDown <= regWriteData & `CPD_RX_BIAS_MASK;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------
   // Unmapped offsets read as zero; soft reset bit always reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regReadData <= `CPD_REG_RESET;
      end else if (clkEn && regRead) begin
         case (regAddr)
            `CPD_ADDR_GENERAL: regReadData <= generalCfg;
            `CPD_ADDR_CLK_MODE: regReadData <= interfaceClockMode;
            `CPD_ADDR_TX_PLL_PD: regReadData <= txAndPllPowerDown;
            `CPD_ADDR_RX_PD_LO: regReadData <= rxChannelPowerDownLo;
            `CPD_ADDR_RX_PD_HI: regReadData <= rxChannelPowerDownHi;
            `CPD_ADDR_RX_BIAS_PD: regReadData <= rxBiasPowerDown;
            default: regReadData <= `CPD_REG_RESET;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Control decode
   // ------------------------------------------------------------
   assign clockModeField = interfaceClockMode[`CPD_CLK_MODE_MSB:`CPD_CLK_MODE_LSB];
   assign txPattern = txAndPllPowerDown[`CPD_TXPD_MSB:`CPD_TXPD_LSB];

   // Patterns other than the three documented ones leave both outputs running
   always_comb begin
      next_clkCtrl.cloneTiming = (clockModeField == `CPD_CLK_MODE_CLONE);
      next_clkCtrl.auxBClockOutEnable = interfaceClockMode[`CPD_BIT_AUXB_CLKOUT];
      next_clkCtrl.auxBClockInvert = interfaceClockMode[`CPD_BIT_AUXB_CLKOUT]
                                     && fullDuplex;
      next_clkCtrl.auxCClockInvert = interfaceClockMode[`CPD_BIT_AUXC_INVERT];
      next_txPower.channelAOff = (txPattern == `CPD_TXPD_A_ONLY)
                                 || (txPattern == `CPD_TXPD_BOTH);
      next_txPower.channelBOff = (txPattern == `CPD_TXPD_B_ONLY)
                                 || (txPattern == `CPD_TXPD_BOTH);
      next_txPower.supportOff = (txPattern == `CPD_TXPD_BOTH);
      next_txPower.biasPowered = 1'b1;
      next_txPower.digitalClockStop = txAndPllPowerDown[`CPD_BIT_TX_DIGITAL]
                                      || !txPathUsed;
      next_rxPower.chAAnalogOff = rxChannelPowerDownLo[`CPD_BIT_RX_ANALOG];
      next_rxPower.chADcBiasOff = rxChannelPowerDownLo[`CPD_BIT_RX_DC_BIAS];
      next_rxPower.chBAnalogOff = rxChannelPowerDownHi[`CPD_BIT_RX_ANALOG];
      next_rxPower.chBDcBiasOff = rxChannelPowerDownHi[`CPD_BIT_RX_DC_BIAS];
      next_rxPower.biasCircuitsOff = rxBiasPowerDown[`CPD_BIT_RX_BIAS_ALL];
      next_rxPower.diffRefBufferOff = rxBiasPowerDown[`CPD_BIT_RX_BIAS_ALL];
      next_rxPower.bandgapPowered = 1'b1;
      next_rxPower.digitalOff = txAndPllPowerDown[`CPD_BIT_RX_DIGITAL]
                                || !rxPathUsed;
      next_pllCtrl.multiplierOff = txAndPllPowerDown[`CPD_BIT_PLL_PD];
      next_pllCtrl.bypassed = txAndPllPowerDown[`CPD_BIT_PLL_PD];
      // Disconnect only steers the clock path; lock logic keeps running
      next_pllCtrl.outputDisconnect = txAndPllPowerDown[`CPD_BIT_PLL_DISCONNECT];
      next_pllCtrl.relock = softResetHit;
   end

   // ------------------------------------------------------------
   // Registered control outputs
   // ------------------------------------------------------------
   // One cycle of latency buys glitch-free analog control lines
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clkCtrl <= '0;
         txPower <= '0;
         rxPower <= '0;
         pllCtrl <= '0;
      end else if (clkEn) begin
         clkCtrl <= next_clkCtrl;
         txPower <= next_txPower;
         rxPower <= next_rxPower;
         pllCtrl <= next_pllCtrl;
      end
   end

   // ------------------------------------------------------------
   // Auxiliary interface pins
   // ------------------------------------------------------------
   // Pin input comes from outside, so two flops before anything reads it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinBSync1 <= 1'b0;
         pinBSync2 <= 1'b0;
      end else if (clkEn) begin
         pinBSync1 <= auxPinBIn;
         pinBSync2 <= pinBSync1;
      end
   end

   // Clock path: the pins follow the interface clock with no flop in between
   assign auxPinBData = pinBSync2;
   assign auxPinBOe = clkCtrl.auxBClockOutEnable;
   assign auxPinBOut = clkCtrl.auxBClockOutEnable
                       && (ifaceClock ^ clkCtrl.auxBClockInvert);
   assign auxPinCOut = ifaceClock ^ clkCtrl.auxCClockInvert;

   // ------------------------------------------------------------
   // Transmit hold
   // ------------------------------------------------------------
   cpd_tx_hold #(.WIDTH(TX_WIDTH)) holdA (
      .clk(clk),
      .rst(rst),
      .clkEn(clkEn),
      .hold(txPower.digitalClockStop),
      .dataIn(txDataA),
      .dataOut(txHeldA)
   );

   cpd_tx_hold #(.WIDTH(TX_WIDTH)) holdB (
      .clk(clk),
      .rst(rst),
      .clkEn(clkEn),
      .hold(txPower.digitalClockStop),
      .dataIn(txDataB),
      .dataOut(txHeldB)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Decoded outputs lag the registers by one edge, so checks against a register
   // skip the edge after it moves and any edge that follows a frozen cycle
   AST_CLONE: assert property (@(posedge clk) disable iff (rst)
      clkEn |=> clkCtrl.cloneTiming == ($past(clockModeField) == `CPD_CLK_MODE_CLONE))
      else $error("clone timing does not follow clock mode field");
   AST_PINB_OE: assert property (@(posedge clk) disable iff (rst)
      auxPinBOe == interfaceClockMode[`CPD_BIT_AUXB_CLKOUT] || !$stable(interfaceClockMode)
      || !$past(clkEn))
      else $error("pin B enable does not follow clock mode bit 2");
   AST_PINB_INV: assert property (@(posedge clk) disable iff (rst)
      clkCtrl.auxBClockInvert |-> clkCtrl.auxBClockOutEnable)
      else $error("pin B inverted while not enabled");
   AST_PINC: assert property (@(posedge clk) disable iff (rst)
      ($past(clkEn) && $stable(interfaceClockMode))
      |-> auxPinCOut == (ifaceClock ^ interfaceClockMode[`CPD_BIT_AUXC_INVERT]))
      else $error("pin C clock polarity wrong");
   AST_TX_DECODE: assert property (@(posedge clk) disable iff (rst)
      (clkEn && txPattern == `CPD_TXPD_A_ONLY) |=> (txPower.channelAOff && !txPower.channelBOff))
      else $error("Tx A only pattern misdecoded");
   AST_TX_BOTH: assert property (@(posedge clk) disable iff (rst)
      txPower.supportOff |-> (txPower.channelAOff && txPower.channelBOff))
      else $error("support off without both Tx outputs off");
   // The outputs still show their reset zeros on the first edge after release
   AST_BIAS_ON: assert property (@(posedge clk) disable iff (rst)
      (!rst && !$past(rst)) |-> (txPower.biasPowered && rxPower.bandgapPowered))
      else $error("bias or bandgap dropped");
   AST_TX_HOLD: assert property (@(posedge clk) disable iff (rst)
      (txPower.digitalClockStop && $past(txPower.digitalClockStop)) |-> $stable(txHeldA))
      else $error("Tx word moved while unclocked");
   AST_SOFT_RESET: assert property (@(posedge clk) disable iff (rst)
      (clkEn && softResetHit) |=> (interfaceClockMode == `CPD_REG_RESET
      && txAndPllPowerDown == `CPD_REG_RESET && rxBiasPowerDown == `CPD_REG_RESET
      && !generalCfg[`CPD_BIT_SOFT_RESET]))
      else $error("soft reset did not restore defaults");
   AST_RELOCK: assert property (@(posedge clk) disable iff (rst)
      pllCtrl.relock |=> !pllCtrl.relock || $past(softResetHit))
      else $error("relock not a pulse");
   AST_PLL: assert property (@(posedge clk) disable iff (rst)
      ($past(clkEn) && $stable(txAndPllPowerDown))
      |-> (pllCtrl.multiplierOff == txAndPllPowerDown[`CPD_BIT_PLL_PD]
      && pllCtrl.bypassed == txAndPllPowerDown[`CPD_BIT_PLL_PD]))
      else $error("PLL bypass disagrees with power-down");
   AST_RX_BIAS: assert property (@(posedge clk) disable iff (rst)
      (clkEn && rxBiasPowerDown[`CPD_BIT_RX_BIAS_ALL]) |=> rxPower.diffRefBufferOff)
      else $error("Rx bias power-down not applied");

   // Main scenarios that the bench is expected to reach
   COV_CLONE: cover property (@(posedge clk) disable iff (rst) clkCtrl.cloneTiming);
   COV_PINB_INV: cover property (@(posedge clk) disable iff (rst)
      clkCtrl.auxBClockInvert);
   COV_TX_BOTH: cover property (@(posedge clk) disable iff (rst) txPower.supportOff);
   COV_HOLD: cover property (@(posedge clk) disable iff (rst)
      txPower.digitalClockStop [*3]);
   COV_SOFT_RESET: cover property (@(posedge clk) disable iff (rst) pllCtrl.relock);

endmodule

`default_nettype wire

// ---- bench/cpd_top_test.sv ----
// Self-checking testbench of the clock and power-down control bank
`timescale 1ns/1ps
`default_nettype none
`include "cpd_defines.svh"

module cpd_top_test;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
   } cpd_row_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWriteData = 8'h00;
   logic fullDuplex = 1'b1;
   logic txPathUsed = 1'b1;
   logic rxPathUsed = 1'b1;
   logic ifaceClock = 1'b0;
   logic auxPinBIn = 1'b0;
   logic [11:0] txDataA = 12'h000;
   logic [11:0] txDataB = 12'h000;
   logic [7:0] regReadData;
   logic auxPinBOut, auxPinBOe, auxPinBData, auxPinCOut;
   logic [11:0] txHeldA, txHeldB;
   logic [7:0] v;
   logic r0, r1;
   cpd_pkg::cpd_clk_ctrl_type clkCtrl;
   cpd_pkg::cpd_tx_power_type txPower;
   cpd_pkg::cpd_rx_power_type rxPower;
   cpd_pkg::cpd_pll_ctrl_type pllCtrl;
   int errCount = 0;
   int nTests = 0;
   // Write-then-readback table; unmapped offset 0x06 must read zero
   cpd_row_type rows [7] = '{
      '{8'h01, 8'hff, `CPD_CLK_MODE_MASK}, '{8'h02, 8'hff, `CPD_TX_PLL_PD_MASK},
      '{8'h03, 8'hff, `CPD_RX_CH_MASK}, '{8'h04, 8'hff, `CPD_RX_CH_MASK},
      '{8'h05, 8'hff, `CPD_RX_BIAS_MASK}, '{8'h06, 8'hff, 8'h00},
      '{8'h00, 8'hc0, `CPD_GENERAL_MASK}};

   cpd_top #(.TX_WIDTH(12)) dut (.clk(clk), .rst(rst), .clkEn(clkEn), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
      .regReadData(regReadData), .fullDuplex(fullDuplex), .txPathUsed(txPathUsed),
      .rxPathUsed(rxPathUsed), .ifaceClock(ifaceClock), .auxPinBIn(auxPinBIn),
      .auxPinBOut(auxPinBOut), .auxPinBOe(auxPinBOe), .auxPinBData(auxPinBData),
      .auxPinCOut(auxPinCOut), .txDataA(txDataA), .txDataB(txDataB), .txHeldA(txHeldA),
      .txHeldB(txHeldB), .clkCtrl(clkCtrl), .txPower(txPower), .rxPower(rxPower),
      .pllCtrl(pllCtrl));

   // 100 MHz clock
   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errCount++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic endSim;
      if (errCount == 0 && nTests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Strobe is held for exactly one taking edge, then dropped at that edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regReadData;
   endtask
   // Let one more edge land, since decoded outputs lag the registers
   task automatic settle;
      @(posedge clk);
      #1;
   endtask

   // Watchdog: every wait is a fixed count, this only guards a stuck run
   initial begin
      repeat (5000) @(posedge clk);
      errCount++;
      endSim();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      settle();
      check({clkCtrl, txPower, rxPower, pllCtrl}, {4'h0, 5'h02, 8'h02, 4'h0});
      for (int i = 1; i < 6; i++) begin
         rd(8'(i), v);
         check(v, 8'h00);
      end
      // Ordinary cases: readback shows only implemented bits
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, v);
         check(v, rows[i].rdata);
      end
      // Clone timing, pin B clock output with duplex inversion, pin C inversion
      wr(8'h01, 8'he6);
      settle();
      check(clkCtrl, 4'hf);
      for (int lv = 0; lv < 2; lv++) begin
         @(posedge clk) ifaceClock <= 1'(lv);
         #1 check({auxPinBOe, auxPinBOut, auxPinCOut}, {1'b1, ~1'(lv), ~1'(lv)});
      end
      @(posedge clk) fullDuplex <= 1'b0;
      settle();
      check({clkCtrl, auxPinBOut}, {4'hd, ifaceClock});
      wr(8'h01, 8'hc0);
      settle();
      check({clkCtrl, auxPinBOe, auxPinBOut, auxPinCOut}, {4'h0, 2'b00, ifaceClock});
      // Every transmit output power-down pattern; bias always stays powered
      for (int p = 0; p < 8; p++) begin
         wr(8'h02, {3'(p), 5'h00});
         settle();
         check(txPower, {p == 4 || p == 7, p == 2 || p == 7, p == 7, 2'b10});
      end
      // Transmit words freeze while the digital section is unclocked
      @(posedge clk) txDataA <= 12'h5a5;
      txDataB <= 12'ha5a;
      settle();
      check({txHeldA, txHeldB}, {12'h5a5, 12'ha5a});
      wr(8'h02, 8'h10);
      settle();
      @(posedge clk) txDataA <= 12'h123;
      settle();
      settle();
      check({txPower.digitalClockStop, txHeldA}, {1'b1, 12'h5a5});
      wr(8'h02, 8'h00);
      settle();
      settle();
      check(txHeldA, 12'h123);
      @(posedge clk) txPathUsed <= 1'b0;
      rxPathUsed <= 1'b0;
      settle();
      settle();
      check({txPower.digitalClockStop, rxPower.digitalOff}, 2'b11);
      @(posedge clk) txPathUsed <= 1'b1;
      rxPathUsed <= 1'b1;
      // Receive channel, bias and digital power-down
      wr(8'h03, 8'hc0);
      wr(8'h04, 8'h40);
      wr(8'h05, 8'h80);
      wr(8'h02, 8'h08);
      settle();
      check(rxPower, 8'hdf);
      wr(8'h02, 8'h06);
      settle();
      check(pllCtrl, 4'he);
      // Pin B input reaches the logic only after two synchronising flops
      @(posedge clk) auxPinBIn <= 1'b1;
      settle();
      check(auxPinBData, 1'b0);
      settle();
      check(auxPinBData, 1'b1);
      // Writes are ignored while the clock enable is low
      @(posedge clk) clkEn <= 1'b0;
      wr(8'h01, 8'he6);
      @(posedge clk) clkEn <= 1'b1;
      rd(8'h01, v);
      check(v, 8'hc0);
      // Soft reset: one relock pulse, all six registers back to zero
      wr(8'h00, 8'h20);
      #1 r0 = pllCtrl.relock;
      settle();
      r1 = pllCtrl.relock;
      check({r0 | r1, r0 & r1}, 2'b10);
      for (int i = 0; i < 6; i++) begin
         rd(8'(i), v);
         check(v, 8'h00);
      end
      // Asynchronous reset in mid-run
      wr(8'h01, 8'he6);
      settle();
      @(posedge clk) rst <= 1'b1;
      #1 check({clkCtrl, pllCtrl}, 8'h00);
      @(posedge clk) rst <= 1'b0;
      rd(8'h01, v);
      check(v, 8'h00);
      endSim();
   end
endmodule
`default_nettype wire
